//--- hdl/rsc_pkg.sv
// Operation
// - Any active reset source drives the master system reset.
// - Each reset type sets its own cause flag in the status register.
// - Power-on reset clears all flags except brown-out and power-on, set.
// - Software may write flags freely; writing one never causes a reset.
// - Trap conflict resets and sets bit 15; power-on or a software write clears it.
// - Illegal opcode or uninitialised pointer resets, sets bit 14.
// - Configuration mismatch resets and sets bit 9.
// - Master clear pin reset sets bit 7.
// - Software reset instruction resets and sets bit 6.
// - Watchdog time-out sets bit 4; power-saving instruction clears it.
// - Sleep instruction sets bit 3, idle instruction sets bit 2.
// - Sleep with deep-sleep enable set sets bit 10.
// - Bit 1 set by brown-out and power-on; bit 0 by power-on only.
// - Bit 13 turns the brown-out detector on or off; resets to zero.
// - Bit 5 enables the watchdog; the fuse forces it on.
// - Bit 8 keeps memory bias on in sleep; clear puts regulator standby.
// - With switching on, power-on/brown-out use fuses or fast RC on two-speed, others keep current.
// - With switching off, reset clock source comes from fuses, except fast RC on two-speed cold starts.
// - Power-on delay plus timer after power-on; timer only after brown-out.
// - Power-up timer lasts 64 ms when enabled, zero when disabled.
// - Crystal start-up counter of 10 bits counts 1024 oscillator periods.
// - Oscillator start-up runs beside reset delay; run needs both done.
// - Two-speed start-up starts on the fast internal RC oscillator.
// - Software brown-out control acts only when the fuse field is 01.
package rsc_pkg;
    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int POWER_UP_TIMER_MS = 64;
    localparam int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_MS * 1000000 / CLK_PERIOD_NS;
    localparam int POR_DELAY_NS = 2000;
    localparam int POR_CYCLES = (POR_DELAY_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int TIMER_W = 22;
    localparam int OST_W = 10;
    localparam logic [OST_W-1:0] OST_LAST = 10'h3ff;
    // ********************************************************************
    // Register map and fields
    // ********************************************************************
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'h00;
    localparam logic [15:0] RESET_CAUSE_POR = 16'h0003;
    localparam logic [15:0] RESET_CAUSE_WMASK = 16'hf7ff;
    localparam int BIT_TRAP = 15;
    localparam int BIT_ILLOP = 14;
    localparam int BIT_SOFT_BROWNOUT_ENABLE = 13;
    localparam int BIT_LVR = 12;
    localparam int BIT_DSLP = 10;
    localparam int BIT_CFGM = 9;
    localparam int BIT_PROGRAM_MEMORY_SLEEP_POWER = 8;
    localparam int BIT_PIN = 7;
    localparam int BIT_SWR = 6;
    localparam int BIT_SOFT_WATCHDOG_ENABLE = 5;
    localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 4;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_IDLE = 2;
    localparam int BIT_BOR = 1;
    localparam int BIT_POR = 0;
    localparam logic [1:0] BROWNOUT_ENABLE_FUSE_SOFT = 2'h1;
    localparam logic [1:0] BROWNOUT_ENABLE_FUSE_OFF = 2'h0;
    localparam logic [2:0] OSC_SEL_FAST_RC = 3'h0;
    // ********************************************************************
    // Reset sequencer states, Gray coded from power-on wait through run to hold
    // ********************************************************************
    typedef enum logic [1:0] {
        ST_POR_WAIT = 2'h0,
        ST_DELAY = 2'h1,
        ST_RUN = 2'h3,
        ST_HOLD = 2'h2
    } rsc_state_e;
endpackage

//--- hdl/rsc_seq_if.sv
`timescale 1ns/10ps
`default_nettype none
// Links the sequencer with its delay timer and oscillator start counter
interface rsc_seq_if;
    logic load;
    logic [rsc_pkg::TIMER_W-1:0] load_val;
    logic done;
    logic osc_start;
    logic osc_crystal;
    logic osc_tick;
    logic osc_ready;
    modport timer (input load, input load_val, output done);
    modport osc (input osc_start, input osc_crystal, input osc_tick,
        output osc_ready);
    modport ctl (output load, output load_val, output osc_start,
        output osc_crystal, output osc_tick, input done, input osc_ready);
endinterface
`default_nettype wire

//--- hdl/rsc_delay_timer.sv
`timescale 1ns/10ps
`default_nettype none
module rsc_delay_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    rsc_seq_if.timer seq
);
    logic [rsc_pkg::TIMER_W-1:0] count_q;

    // ********************************************************************
    // Down counter; a zero load means no delay at all
    // ********************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= '0;
        end else if (seq.load) begin
            count_q <= seq.load_val;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    // Load takes precedence so a fresh reset restarts the wait
    assign seq.done = (count_q == '0) && !seq.load;
endmodule // rsc_delay_timer
`default_nettype wire

//--- hdl/rsc_osc_startup.sv
`timescale 1ns/10ps
`default_nettype none
module rsc_osc_startup (
    input wire logic clk_i,
    input wire logic rst_i,
    rsc_seq_if.osc seq
);
    logic [rsc_pkg::OST_W-1:0] count_q;
    logic running_q;
    logic ready_q;

    // ********************************************************************
    // Crystal start-up: 1024 oscillator periods before release
    // ********************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= '0;
            running_q <= 1'b0;
            ready_q <= 1'b0;
        end else if (seq.osc_start) begin
            count_q <= '0;
            running_q <= seq.osc_crystal;
            ready_q <= !seq.osc_crystal;
        end else if (running_q && seq.osc_tick) begin
            count_q <= count_q + 1'b1;
            if (count_q == rsc_pkg::OST_LAST) begin
                running_q <= 1'b0;
                ready_q <= 1'b1;
            end
        end
    end

    assign seq.osc_ready = ready_q;
endmodule // rsc_osc_startup
`default_nettype wire

//--- hdl/rsc_top.sv
`timescale 1ns/10ps
`default_nettype none
module rsc_top #(
    parameter int POWER_UP_TIMER_CYCLES = rsc_pkg::POWER_UP_TIMER_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Reset and event sources
    input wire logic pin_reset_i,
    input wire logic soft_reset_i,
    input wire logic watchdog_timeout_i,
    input wire logic brownout_i,
    input wire logic trap_conflict_i,
    input wire logic illegal_op_i,
    input wire logic config_mismatch_i,
    input wire logic power_saving_instruction_sleep_i,
    input wire logic power_saving_instruction_idle_i,
    input wire logic deep_sleep_enable_i,
    // Configuration fuses and straps
    input wire logic clock_switch_enable_i,
    input wire logic two_speed_enable_i,
    input wire logic power_up_timer_enable_i,
    input wire logic watchdog_enable_fuse_i,
    input wire logic [1:0] brownout_enable_fuse_i,
    input wire logic [2:0] oscillator_select_fuse_i,
    input wire logic [2:0] current_oscillator_i,
    // Oscillator status
    input wire logic primary_is_crystal_i,
    input wire logic osc_tick_i,
    input wire logic pll_locked_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Outputs to core and peripherals
    output logic master_system_reset_o,
    output logic code_run_o,
    output logic [2:0] reset_osc_select_o,
    output logic brownout_detector_on_o,
    output logic watchdog_enable_o,
    output logic program_memory_sleep_power_o,
    output logic regulator_standby_sleep_o,
    output logic low_voltage_regulator_select_o
);
    // ********************************************************************
    // Declarations
    // ********************************************************************
    localparam logic [rsc_pkg::TIMER_W-1:0] POWER_UP_TIMER_LOAD =
        rsc_pkg::TIMER_W'(POWER_UP_TIMER_CYCLES);
    localparam logic [rsc_pkg::TIMER_W-1:0] POR_LOAD =
        rsc_pkg::TIMER_W'(rsc_pkg::POR_CYCLES);

    rsc_seq_if seq ();
    rsc_pkg::rsc_state_e state_q;
    rsc_pkg::rsc_state_e state_d;
    logic [15:0] cause_q;
    logic [15:0] cause_d;
    logic [15:0] hw_set;
    logic [15:0] wr_mask;
    logic [15:0] cause_rd;
    logic bor_active;
    logic bor_seen_q;
    logic detector_on;
    logic src_any;
    logic bus_req;
    logic bus_wr;
    logic hit_cause;
    logic enter_delay;
    logic cold_start;
    logic [rsc_pkg::TIMER_W-1:0] power_up_timer_val;
    logic [2:0] osc_sel_d;
    logic [2:0] osc_sel_q;
    logic master_system_reset_q;
    logic run_q;
    logic [31:0] rd_q;
    logic ack_q;
    logic det_q;
    logic wdt_q;
    logic pm_q;
    logic stby_q;
    logic lvr_q;

    // ********************************************************************
    // Submodules
    // ********************************************************************
    rsc_delay_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .seq(seq.timer)
    );

    rsc_osc_startup u_ost (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .seq(seq.osc)
    );

    // ********************************************************************
    // Brown-out detector enable
    // ********************************************************************
    // The software control only counts in the soft fuse mode
    always_comb begin
        if (brownout_enable_fuse_i == rsc_pkg::BROWNOUT_ENABLE_FUSE_SOFT) begin
            detector_on = cause_q[rsc_pkg::BIT_SOFT_BROWNOUT_ENABLE];
        end else begin
            detector_on = brownout_enable_fuse_i != rsc_pkg::BROWNOUT_ENABLE_FUSE_OFF;
        end
    end

    // A brown-out is ignored while the detector is off
    assign bor_active = brownout_i && detector_on;

    // Any active source holds the system in reset
    assign src_any = pin_reset_i | soft_reset_i | watchdog_timeout_i
        | bor_active | trap_conflict_i | illegal_op_i
        | config_mismatch_i;

    // ********************************************************************
    // Reset sequencer
    // ********************************************************************
    // Power-up timer is skipped entirely when not enabled
    assign power_up_timer_val = power_up_timer_enable_i ? POWER_UP_TIMER_LOAD : '0;

    always_comb begin
        state_d = state_q;
        enter_delay = 1'b0;
        case (state_q)
            rsc_pkg::ST_POR_WAIT: begin
                enter_delay = 1'b1;
                state_d = rsc_pkg::ST_DELAY;
            end
            rsc_pkg::ST_DELAY: begin
                if (src_any) begin
                    state_d = rsc_pkg::ST_HOLD;
                end else if (seq.done) begin
                    state_d = rsc_pkg::ST_RUN;
                end
            end
            rsc_pkg::ST_RUN: begin
                if (src_any) begin
                    state_d = rsc_pkg::ST_HOLD;
                end
            end
            rsc_pkg::ST_HOLD: begin
                if (!src_any) begin
                    enter_delay = 1'b1;
                    state_d = rsc_pkg::ST_DELAY;
                end
            end
            default: begin
                state_d = rsc_pkg::ST_POR_WAIT;
            end
        endcase
    end

    // Power-on and brown-out are the cold starts that reload fuses
    assign cold_start = (state_q == rsc_pkg::ST_POR_WAIT) || bor_seen_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= rsc_pkg::ST_POR_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    // Remember a brown-out seen while held, it picks the delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bor_seen_q <= 1'b0;
        end else if (bor_active) begin
            bor_seen_q <= 1'b1;
        end else if (enter_delay) begin
            bor_seen_q <= 1'b0;
        end
    end

    // Delay loads: power-on adds its own delay, brown-out only the timer
    always_comb begin
        seq.load = enter_delay;
        if (state_q == rsc_pkg::ST_POR_WAIT) begin
            seq.load_val = POR_LOAD + power_up_timer_val;
        end else if (bor_seen_q) begin
            seq.load_val = power_up_timer_val;
        end else begin
            seq.load_val = '0;
        end
    end

    // ********************************************************************
    // Clock source selection at reset
    // ********************************************************************
    always_comb begin
        if (!clock_switch_enable_i || cold_start) begin
            osc_sel_d = oscillator_select_fuse_i;
        end else begin
            osc_sel_d = current_oscillator_i;
        end
        if (cold_start && two_speed_enable_i) begin
            osc_sel_d = rsc_pkg::OSC_SEL_FAST_RC;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_sel_q <= rsc_pkg::OSC_SEL_FAST_RC;
        end else if (enter_delay) begin
            osc_sel_q <= osc_sel_d;
        end
    end

    // Start-up counter starts with a cold-start delay, so both run side by side
    assign seq.osc_start = enter_delay && cold_start;
    assign seq.osc_crystal = primary_is_crystal_i;
    assign seq.osc_tick = osc_tick_i;

    // ********************************************************************
    // Reset and run outputs
    // ********************************************************************
    // Registered so every consumer leaves reset on the same edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_system_reset_q <= 1'b1;
        end else begin
            master_system_reset_q <= (state_d != rsc_pkg::ST_RUN);
        end
    end

    // Code runs only once reset delay and clock start-up both finish
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
        end else begin
            run_q <= (state_d == rsc_pkg::ST_RUN) && seq.osc_ready
                && pll_locked_i;
        end
    end

    // ********************************************************************
    // Reset cause and control register
    // ********************************************************************
    always_comb begin
        hw_set = '0;
        hw_set[rsc_pkg::BIT_TRAP] = trap_conflict_i;
        hw_set[rsc_pkg::BIT_ILLOP] = illegal_op_i;
        hw_set[rsc_pkg::BIT_CFGM] = config_mismatch_i;
        hw_set[rsc_pkg::BIT_PIN] = pin_reset_i;
        hw_set[rsc_pkg::BIT_SWR] = soft_reset_i;
        hw_set[rsc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = watchdog_timeout_i;
        hw_set[rsc_pkg::BIT_SLEEP] = power_saving_instruction_sleep_i;
        hw_set[rsc_pkg::BIT_IDLE] = power_saving_instruction_idle_i;
        hw_set[rsc_pkg::BIT_DSLP] = power_saving_instruction_sleep_i
            && deep_sleep_enable_i;
        hw_set[rsc_pkg::BIT_BOR] = bor_active;
    end

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign hit_cause = wb_adr_i == rsc_pkg::ADDR_RESET_CAUSE;
    assign bus_wr = bus_req && wb_we_i && hit_cause;
    assign wr_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}
        & rsc_pkg::RESET_CAUSE_WMASK;

    // Order: software write, then power-saving clear, then hardware set
    always_comb begin
        cause_d = cause_q;
        if (bus_wr) begin
            cause_d = (cause_q & ~wr_mask)
                | (wb_dat_i[15:0] & wr_mask);
        end
        if (power_saving_instruction_sleep_i || power_saving_instruction_idle_i) begin
            cause_d[rsc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
        end
        cause_d = cause_d | hw_set;
    end

    // Power-on sets only the two low flags; writes never cause a reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_q <= rsc_pkg::RESET_CAUSE_POR;
        end else begin
            cause_q <= cause_d;
        end
    end

    // Software brown-out bit reads zero outside the soft fuse mode
    always_comb begin
        cause_rd = cause_q;
        if (brownout_enable_fuse_i != rsc_pkg::BROWNOUT_ENABLE_FUSE_SOFT) begin
            cause_rd[rsc_pkg::BIT_SOFT_BROWNOUT_ENABLE] = 1'b0;
        end
    end

    // ********************************************************************
    // Wishbone slave: one wait-free cycle, unmapped reads give zero
    // ********************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= '0;
        end else if (bus_req && !wb_we_i && hit_cause) begin
            rd_q <= {16'h0000, cause_rd};
        end else begin
            rd_q <= '0;
        end
    end

    // ********************************************************************
    // Control outputs
    // ********************************************************************
    // Fuse forces the watchdog on whatever software wrote
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            det_q <= 1'b0;
            wdt_q <= 1'b0;
            pm_q <= 1'b0;
            stby_q <= 1'b0;
            lvr_q <= 1'b0;
        end else begin
            det_q <= detector_on;
            wdt_q <= watchdog_enable_fuse_i
                || cause_q[rsc_pkg::BIT_SOFT_WATCHDOG_ENABLE];
            pm_q <= cause_q[rsc_pkg::BIT_PROGRAM_MEMORY_SLEEP_POWER];
            stby_q <= !cause_q[rsc_pkg::BIT_PROGRAM_MEMORY_SLEEP_POWER];
            lvr_q <= cause_q[rsc_pkg::BIT_LVR];
        end
    end

    assign master_system_reset_o = master_system_reset_q;
    assign code_run_o = run_q;
    assign reset_osc_select_o = osc_sel_q;
    assign brownout_detector_on_o = det_q;
    assign watchdog_enable_o = wdt_q;
    assign program_memory_sleep_power_o = pm_q;
    assign regulator_standby_sleep_o = stby_q;
    assign low_voltage_regulator_select_o = lvr_q;
    assign wb_dat_o = rd_q;
    assign wb_ack_o = ack_q;
endmodule // rsc_top
`default_nettype wire

//--- tb/rsc_osc_model.sv
`timescale 1ns/10ps
`default_nettype none
// Crystal and PLL behind the combiner: ticks stand still in reset
module rsc_osc_model #(
    parameter int LOCK_CYCLES = 40
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic osc_tick_o,
    output logic pll_locked_o
);
    int cnt_q;
    // One free counter; lock lands after 40 cycles, well inside the start count
    always_ff @(posedge clk_i) begin
        if (rst_i)
            cnt_q <= 0;
        else
            cnt_q <= cnt_q + 1;
    end
    assign osc_tick_o = cnt_q[0];
    assign pll_locked_o = (cnt_q > LOCK_CYCLES);
endmodule // rsc_osc_model
`default_nettype wire

//--- tb/rsc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rsc_assertions #(
    parameter int POWER_UP_TIMER_CYCLES = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_reset_i,
    input wire logic soft_reset_i,
    input wire logic watchdog_timeout_i,
    input wire logic trap_conflict_i,
    input wire logic illegal_op_i,
    input wire logic config_mismatch_i,
    input wire logic watchdog_enable_fuse_i,
    input wire logic [1:0] brownout_enable_fuse_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic master_system_reset_o,
    input wire logic code_run_o,
    input wire logic watchdog_enable_o,
    input wire logic brownout_detector_on_o
);
    // ********
    // Checks
    // ********
    // Brown-out is left out: it only counts while the detector is on
    wire logic src_any = pin_reset_i | soft_reset_i | watchdog_timeout_i
        | trap_conflict_i | illegal_op_i | config_mismatch_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_src_to_rst: assert property (src_any |=> master_system_reset_o)
        else $error("source without system reset");
    a_release_quiet: assert property (
        $fell(master_system_reset_o) |-> !$past(src_any))
        else $error("reset released while a source was active");
    a_ack_one_pulse: assert property (s_req |=> s_ack)
        else $error("bus answer missing or too long");
    a_ack_only_req: assert property (
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("answer without request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside answer");
    a_unused_zero: assert property (
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0 && !wb_dat_o[11])
        else $error("unused bits read nonzero");
    a_wdt_fuse_on: assert property (
        watchdog_enable_fuse_i[*4] |-> watchdog_enable_o)
        else $error("watchdog off with fuse set");
    a_bor_fuse_off: assert property (
        (brownout_enable_fuse_i == 2'h0)[*4] |-> !brownout_detector_on_o)
        else $error("detector on with fuse off");
    a_run_needs_rel: assert property (
        code_run_o |-> !master_system_reset_o)
        else $error("code runs during reset");
endmodule // rsc_assertions
`default_nettype wire

//--- tb/rsc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rsc_top_tb;
    localparam int POWER_UP_TIMER = 20;
    localparam int DLY = 120;
    localparam int POR = rsc_pkg::POR_CYCLES;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [8:0] ev = 9'h0;
    logic csw = 1'b1, two = 1'b0, pwt = 1'b1, wdf = 1'b1, dse = 1'b0;
    logic [1:0] bfz = 2'h1;
    logic [2:0] ofz = 3'h2, cur = 3'h5;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dw = 32'h0;
    wire logic [31:0] dr;
    wire logic ack, msr, run, tick, lock, bdo, wdo, pmo, rso, lvo;
    wire logic [2:0] osel;
    logic [31:0] expq[$];
    int num_errors = 0, samples_checked = 0, n, tk;
    int seed = 32'hedf2;
    int flg [8] = '{7, 6, 4, 15, 14, 9, 3, 2};
    rsc_top #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER)) u_rsc_top (
        .clk_i, .rst_i, .pin_reset_i(ev[0]), .soft_reset_i(ev[1]),
        .watchdog_timeout_i(ev[2]), .brownout_i(ev[8]),
        .trap_conflict_i(ev[3]), .illegal_op_i(ev[4]),
        .config_mismatch_i(ev[5]), .power_saving_instruction_sleep_i(ev[6]),
        .power_saving_instruction_idle_i(ev[7]), .deep_sleep_enable_i(dse),
        .clock_switch_enable_i(csw), .two_speed_enable_i(two),
        .power_up_timer_enable_i(pwt), .watchdog_enable_fuse_i(wdf),
        .brownout_enable_fuse_i(bfz), .oscillator_select_fuse_i(ofz),
        .current_oscillator_i(cur), .primary_is_crystal_i(1'b1),
        .osc_tick_i(tick), .pll_locked_i(lock), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
        .master_system_reset_o(msr), .code_run_o(run),
        .reset_osc_select_o(osel), .brownout_detector_on_o(bdo),
        .watchdog_enable_o(wdo), .program_memory_sleep_power_o(pmo),
        .regulator_standby_sleep_o(rso),
        .low_voltage_regulator_select_o(lvo));
    rsc_osc_model u_rsc_osc_model (.clk_i, .rst_i, .osc_tick_o(tick),
        .pll_locked_o(lock));
    // ********
    // Helpers
    // ********
    always #10 clk_i = ~clk_i;
    // Oscillator periods since the last power-on release
    always @(posedge clk_i) begin
        if (rst_i)
            tk <= 0;
        else if (tick)
            tk <= tk + 1;
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Read data is taken at the answering edge, oldest note first
    always @(posedge clk_i) begin
        if (ack === 1'b1 && !we && expq.size() > 0)
            check("reg_read", dr, expq.pop_front());
    end
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [15:0] d, input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dw <= {16'h0, d};
        // No cycle count assumed: only the watchdog ends a missing answer
        while (ack !== 1'b1) @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(1'b0, a, 16'h0, 4'h3);
    endtask
    // Bounded wait for the system reset to drop; n keeps the edge count
    task automatic wait_rel();
        n = 0;
        while (msr !== 1'b0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic pulse(input int i, input int len, input logic e);
        ev[i] <= 1'b1;
        repeat (len) @(posedge clk_i);
        ev[i] <= 1'b0;
        @(posedge clk_i);
        check("sys_reset", 32'(msr), 32'(e));
        wait_rel();
    endtask
    task automatic give_verdict();
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        give_verdict();
    end
    // ********
    // Scenarios
    // ********
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_rel();
        check("por_delay", 32'(n >= DLY && n <= DLY + 6), 32'h1);
        check("osc_sel", 32'(osel), 32'h2);
        for (int i = 0; i < 5000 && run !== 1'b1; i++) @(posedge clk_i);
        check("osc_count", 32'(tk >= 1024 && run === 1'b1), 32'h1);
        rd(8'h0, 32'h3);
        wb(1'b1, 8'h0, 16'hffff, 4'h3);
        check("no_reset", 32'(msr), 32'h0);
        rd(8'h0, 32'hf7ff);
        check("ctrl", 32'({bdo, wdo, pmo, rso, lvo}), 32'h1d);
        wdf <= 1'b0;
        wb(1'b1, 8'h0, 16'h0, 4'h3);
        repeat (2) @(posedge clk_i);
        check("ctrl", 32'({bdo, wdo, pmo, rso, lvo}), 32'h2);
        wb(1'b1, 8'h0, 16'ha5a5, 4'h2);
        wb(1'b1, 8'h10, 16'hffff, 4'h3);
        rd(8'h10, 32'h0);
        rd(8'h0, 32'ha500);
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, 8'h0, 16'h0, 4'h3);
            pulse(i, ($random(seed) & 3) + 1, i < 6);
            check("quick", 32'(n <= 3), 32'h1);
            rd(8'h0, 32'h1 << flg[i]);
        end
        wb(1'b1, 8'h0, 16'h0, 4'h3);
        pulse(2, 1, 1'b1);
        dse <= 1'b1;
        pulse(6, 1, 1'b0);
        rd(8'h0, 32'h0408);
        pulse(0, 2, 1'b1);
        check("osc_sel", 32'(osel), 32'h5);
        csw <= 1'b0;
        pulse(0, 2, 1'b1);
        check("osc_sel", 32'(osel), 32'h2);
        csw <= 1'b1;
        bfz <= 2'h3;
        wb(1'b1, 8'h0, 16'h0, 4'h3);
        pulse(8, 3, 1'b1);
        check("bor_delay", 32'(n >= POWER_UP_TIMER && n <= POWER_UP_TIMER + 4), 32'h1);
        check("osc_sel", 32'(osel), 32'h2);
        rd(8'h0, 32'h2);
        bfz <= 2'h0;
        wb(1'b1, 8'h0, 16'hffff, 4'h3);
        rd(8'h0, 32'hd7ff);
        check("bor_on", 32'(bdo), 32'h0);
        // Timer off: a second power-on waits for its own delay only
        two <= 1'b1;
        pwt <= 1'b0;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_rel();
        check("por_only", 32'(n >= POR && n <= POR + 6), 32'h1);
        check("osc_sel", 32'(osel), 32'h0);
        rd(8'h0, 32'h3);
        give_verdict();
    end
endmodule // rsc_top_tb
bind rsc_top rsc_assertions #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES)) u_rsc_assertions (
    .clk_i, .rst_i, .pin_reset_i, .soft_reset_i, .watchdog_timeout_i,
    .trap_conflict_i, .illegal_op_i, .config_mismatch_i,
    .watchdog_enable_fuse_i, .brownout_enable_fuse_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .master_system_reset_o, .code_run_o,
    .watchdog_enable_o, .brownout_detector_on_o);
`default_nettype wire
